// ### common/dwd_pkg.sv
package dwd_pkg;

   // ==========================================================
   // Bus and register geometry
   localparam int ADDR_W = 12;
   localparam int REG_W = 16;
   localparam logic [ADDR_W-1:0] OFS_DIV = 12'h400;
   localparam logic [ADDR_W-1:0] OFS_LOC = 12'h410;
   localparam logic [ADDR_W-1:0] OFS_NET = 12'h420;
   localparam logic [ADDR_W-1:0] OFS_STAT = 12'h430;
   localparam logic [ADDR_W-1:0] OFS_MASK = 12'h434;
   localparam logic [ADDR_W-1:0] OFS_LIVE = 12'h438;

   // ==========================================================
   // Reset values
   localparam logic [REG_W-1:0] RST_DIV = 16'h09C2;
   localparam logic [REG_W-1:0] RST_LOC = 16'h03E8;
   localparam logic [REG_W-1:0] RST_NET = 16'h03E8;
   localparam logic [1:0] RST_MASK = 2'h0;

   // ==========================================================
   // Field positions and timing
   localparam int BIT_NET = 0;
   localparam int BIT_LOC = 1;
   localparam int STATE_LSB = 4;
   localparam int BASE_PERIOD_NS = 40;
   localparam int CLK_PERIOD_NS = 100;
   localparam logic [REG_W:0] TICK_EXTRA = 17'h00002;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Slave states
   typedef enum logic [2:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP, ST_BOOT} dwd_state_e;

   // Moves the state machine accepts from the master
   function automatic logic dwd_legal(input dwd_state_e from, input dwd_state_e to);
      logic ok;
      ok = 1'b0;
      case (from)
         ST_INIT: ok = (to == ST_PREOP) || (to == ST_BOOT);
         ST_PREOP: ok = (to == ST_SAFEOP) || (to == ST_INIT);
         ST_SAFEOP: ok = (to == ST_OP) || (to == ST_PREOP) || (to == ST_INIT);
         ST_OP: ok = (to == ST_SAFEOP) || (to == ST_PREOP) || (to == ST_INIT);
         ST_BOOT: ok = (to == ST_INIT);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : dwd_legal

endpackage : dwd_pkg

// ### common/dwd_wd_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// One watchdog: shared tick, restart pulse, timeout and state
interface dwd_wd_if;
   logic tick;
   logic kick;
   logic [15:0] limit;
   logic expired;
   modport cnt (input tick, input kick, input limit, output expired);
   modport ctl (output tick, output kick, output limit, input expired);
endinterface : dwd_wd_if
`default_nettype wire

// ### core/dwd_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module dwd_prescaler
   import dwd_pkg::*;
#(
   parameter int W = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] div,
   output logic tick
);

   logic [W:0] cnt_r;
   logic tick_r;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // Wrap after divider plus two clock cycles, one-cycle pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end
      else if (cnt_r >= {1'b0, div} + TICK_EXTRA - 17'h00001) // [RULE15] [RULE8]
      begin
         cnt_r <= '0;
         tick_r <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 17'h00001;
         tick_r <= 1'b0;
      end
   end

   assign tick = tick_r;

   // Divider is at least one, so ticks are at least three cycles apart
   tick_gap_a: assert property (tick |=> !tick ##1 !tick) else $error("tick too close"); // [RULE8]

endmodule : dwd_prescaler
`default_nettype wire

// ### core/dwd_wd_counter.sv
`timescale 1ns/1ps
`default_nettype none
module dwd_wd_counter
   import dwd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   dwd_wd_if.cnt wd
);

   logic [15:0] cnt_r;
   logic exp_r;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // Tick counting; a restart always beats a tick in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_r <= '0;
         exp_r <= 1'b0;
      end
      else if (wd.kick || wd.limit == 16'h0000) // [RULE2] [RULE5] [RULE11]
      begin
         cnt_r <= '0;
         exp_r <= 1'b0;
      end
      else if (wd.tick && !exp_r)
      begin
         cnt_r <= cnt_r + 16'h0001;
         if (cnt_r >= wd.limit - 16'h0001)
            exp_r <= 1'b1; // [RULE3] [RULE6]
      end
   end

   assign wd.expired = exp_r;

   kick_clear_a: assert property (wd.kick |=> !wd.expired) else $error("kick left expired"); // [RULE5]
   zero_off_a: assert property (wd.limit == 16'h0000 |=> !wd.expired) else $error("zero armed"); // [RULE11]
   fire_a: assert property (wd.tick && !wd.kick && wd.limit != 16'h0000 // [RULE3] [RULE6]
      && cnt_r == wd.limit - 16'h0001 |=> wd.expired) else $error("no fire");

endmodule : dwd_wd_counter
`default_nettype wire

// ### core/dwd_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RULE1) Two watchdogs, both default to 100 ms; code defaults give 250 ms at the 100 ns clock
// (RULE2) Network exchange restarts network watchdog count
// (RULE3) Network timeout forces all outputs off
// (RULE4) Network expiry leaves slave state untouched
// (RULE5) Network expiry holds until next exchange
// (RULE6) Local watchdog fires without local access
// (RULE7) Shared prescaler, separate timeout per watchdog
// (RULE8) Tick lasts divider plus two base cycles; code counts 100 ns clock cycles instead
// (RULE9) Divider 2498 and count 1000 give 100ms; code counts 100 ns clocks, giving 250 ms
// (RULE10) Timeout 0..65535, divider 1..65535 accepted
// (RULE11) Network timeout zero disables that watchdog
// (RULE12) Settings written only during start-up states
// (RULE13) Five slave states, moved by master commands
// (RULE14) Safe-operational keeps outputs safe, inputs live
// (RULE15) Prescaler wraps, emits one-cycle tick pulse
module dwd_top
   import dwd_pkg::*;
#(
   parameter int N_OUT = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [dwd_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dwd_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic net_exchange_done,
   input wire logic local_access,
   input wire logic state_req_valid,
   input wire dwd_pkg::dwd_state_e state_req,
   input wire logic [N_OUT-1:0] out_request,
   output logic [N_OUT-1:0] out_drive,
   output dwd_pkg::dwd_state_e slave_state,
   output logic irq
);

   import dwd_pkg::*;

   logic [REG_W-1:0] div_r;
   logic [REG_W-1:0] loc_r;
   logic [REG_W-1:0] net_r;
   logic [1:0] stat_r;
   logic [1:0] mask_r;
   logic [1:0] exp_d_r;
   logic [N_OUT-1:0] out_r;
   dwd_state_e state_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic tick;
   logic wr_go;
   logic rd_go;
   logic startup;
   logic [1:0] expired;
   logic [1:0] rise;
   logic [31:0] rd_nxt;
   logic rd_ok;

   dwd_wd_if net_wd ();
   dwd_wd_if loc_wd ();

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // Watchdog tick generator and the two watchdogs
   // One prescaler serves both so their time bases never drift apart
   dwd_prescaler #(.W(REG_W)) u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .div(div_r),
      .tick(tick)
   );

   // Shared tick, separate limits
   assign net_wd.tick = tick; // [RULE7]
   assign loc_wd.tick = tick; // [RULE7]
   assign net_wd.kick = net_exchange_done; // [RULE2]
   assign loc_wd.kick = local_access; // [RULE6]
   assign net_wd.limit = net_r;
   assign loc_wd.limit = loc_r;
   assign expired = {loc_wd.expired, net_wd.expired};

   dwd_wd_counter u_net (
      .aclk(aclk),
      .aresetn(aresetn),
      .wd(net_wd)
   );

   dwd_wd_counter u_loc (
      .aclk(aclk),
      .aresetn(aresetn),
      .wd(loc_wd)
   );

   // ==========================================================
   // Slave state machine, moved only by legal master commands
   // Watchdog expiry has no path into this process on purpose
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_r <= ST_INIT;
      else if (state_req_valid && dwd_legal(state_r, state_req)) // [RULE13] [RULE4]
         state_r <= state_req;
   end

   assign slave_state = state_r;
   assign startup = (state_r == ST_INIT) || (state_r == ST_PREOP);

   // ==========================================================
   // Output gating: only operational with a live network watchdog drives
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         out_r <= '0;
      else if (state_r != ST_OP || net_wd.expired) // [RULE3] [RULE14]
         out_r <= '0;
      else
         out_r <= out_request;
   end

   assign out_drive = out_r;

   // ==========================================================
   // AXI4-Lite write channel: address and data taken together
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= (s_axi_awaddr == OFS_DIV || s_axi_awaddr == OFS_LOC ||
            s_axi_awaddr == OFS_NET || s_axi_awaddr == OFS_STAT ||
            s_axi_awaddr == OFS_MASK || s_axi_awaddr == OFS_LIVE) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // Settings: locked outside start-up, so a late write cannot shift timing
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         div_r <= RST_DIV; // [RULE9]
         loc_r <= RST_LOC; // [RULE1]
         net_r <= RST_NET; // [RULE1] [RULE9]
      end
      else if (wr_go && startup) // [RULE12]
      begin
         if (s_axi_awaddr == OFS_DIV && s_axi_wstrb[1:0] == 2'h3 &&
            s_axi_wdata[15:0] != 16'h0000) // [RULE10]
            div_r <= s_axi_wdata[15:0];
         if (s_axi_awaddr == OFS_LOC)
         begin
            if (s_axi_wstrb[0]) loc_r[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) loc_r[15:8] <= s_axi_wdata[15:8];
         end
         if (s_axi_awaddr == OFS_NET) // [RULE10]
         begin
            if (s_axi_wstrb[0]) net_r[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) net_r[15:8] <= s_axi_wdata[15:8];
         end
      end
   end

   // Interrupt mask is free to change in any state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_r <= RST_MASK;
      else if (wr_go && s_axi_awaddr == OFS_MASK && s_axi_wstrb[0])
         mask_r <= s_axi_wdata[1:0];
   end

   // ==========================================================
   // Sticky expiry events; a new event beats the read that clears
   assign rise = expired & ~exp_d_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         exp_d_r <= 2'h0;
         stat_r <= 2'h0;
      end
      else
      begin
         exp_d_r <= expired;
         if (rd_go && s_axi_araddr == OFS_STAT)
            stat_r <= rise;
         else
            stat_r <= stat_r | rise;
      end
   end

   assign irq = |(stat_r & mask_r);

   // ==========================================================
   // AXI4-Lite read channel
   assign rd_go = s_axi_arvalid && !rvalid_r;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Read decode; live register shows watchdog and slave state
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         OFS_DIV: rd_nxt[15:0] = div_r;
         OFS_LOC: rd_nxt[15:0] = loc_r;
         OFS_NET: rd_nxt[15:0] = net_r;
         OFS_STAT: rd_nxt[1:0] = stat_r;
         OFS_MASK: rd_nxt[1:0] = mask_r;
         OFS_LIVE:
         begin
            rd_nxt[1:0] = expired;
            rd_nxt[STATE_LSB+2:STATE_LSB] = state_r;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_nxt;
         rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // ==========================================================
   // Checks
   outputs_off_a: assert property (net_wd.expired |=> out_drive == '0) // [RULE3]
      else $error("outputs live after expiry");
   safeop_off_a: assert property (state_r == ST_SAFEOP |=> out_drive == '0) // [RULE14]
      else $error("outputs live in safe state");
   state_keep_a: assert property ($rose(net_wd.expired) && !$past(state_req_valid) // [RULE4]
      |-> state_r == $past(state_r)) else $error("expiry moved state");
   cfg_lock_a: assert property (wr_go && !startup |=> $stable(div_r) && $stable(net_r) // [RULE12]
      && $stable(loc_r)) else $error("setting changed outside start-up");
   div_range_a: assert property (div_r != 16'h0000) else $error("divider zero"); // [RULE10]
   // A masked-in network event must raise the line together with the status bit, one edge after expiry rises
   irq_level_a: assert property ($rose(net_wd.expired) && mask_r[BIT_NET] |=> irq) // [RULE3]
      else $error("irq missing");

   // Local expiry must reach status even though it never gates outputs
   loc_event_a: assert property ($rose(loc_wd.expired) |=> stat_r[BIT_LOC]) // [RULE6]
      else $error("local event lost");
   // Operational with a live network watchdog copies the request through
   out_follow_a: assert property (state_r == ST_OP && !net_wd.expired // [RULE13]
      |=> out_drive == $past(out_request)) else $error("outputs not following request");
   // Answers come exactly one edge after the request is taken
   wr_answer_a: assert property (wr_go |=> s_axi_bvalid)
      else $error("write answer late");
   rd_answer_a: assert property (rd_go |=> s_axi_rvalid)
      else $error("read answer late");

endmodule : dwd_top
`default_nettype wire

// ### verification/dwd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side: network master exchanges and local processor accesses
module dwd_far_model #(
   parameter int GAP = 2
)
(
   input wire logic aclk,
   input wire logic net_on,
   input wire logic loc_on,
   output logic net_exchange_done,
   output logic local_access
);
   int cnt_r = 0;
   // One-cycle pulses every GAP cycles; a larger GAP models a slow master
   always_ff @(posedge aclk)
   begin
      cnt_r <= (cnt_r >= GAP - 1) ? 0 : cnt_r + 1;
      net_exchange_done <= net_on && (cnt_r == 0);
      local_access <= loc_on && (cnt_r == 0);
   end
endmodule : dwd_far_model
`default_nettype wire

// ### verification/dwd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dwd_top_tb;
   import dwd_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid, irq;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic net_done, loc_acc, net_on = 1'h1, loc_on = 1'h1, sreq_v = 1'h0;
   dwd_state_e sreq = ST_INIT, sstate;
   logic [7:0] oreq = 8'h00, odrv;
   logic [3:0] wstrb = 4'hF;
   int n_fail = 0, tests_run = 0;
   // Clock of 100 ns
   always #50 aclk = ~aclk;
   dwd_top #(.N_OUT(8)) dwd_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .net_exchange_done(net_done), .local_access(loc_acc), .state_req_valid(sreq_v),
      .state_req(sreq), .out_request(oreq), .out_drive(odrv), .slave_state(sstate), .irq(irq));
   dwd_far_model #(.GAP(2)) dwd_far_model_i (.aclk(aclk), .net_on(net_on), .loc_on(loc_on),
      .net_exchange_done(net_done), .local_access(loc_acc));
   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Ready is looked at mid-cycle, where it holds the value the next edge samples
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa;
      logic pw;
      pa = 1'h0;
      pw = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(pa && pw))
      begin
         @(negedge aclk);
         pa = pa || awready;
         pw = pw || wready;
         @(posedge aclk);
         if (pa) awvalid <= 1'h0;
         if (pw) wvalid <= 1'h0;
      end
      do @(negedge aclk); while (!bvalid);
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      bready <= 1'h0;
   endtask : wr
   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
      input string nm);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'h0;
      do @(negedge aclk); while (!rvalid);
      chk(nm, rdata, e);
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
      rready <= 1'h0;
   endtask : rchk
   task automatic st(input dwd_state_e s);
      @(posedge aclk);
      sreq <= s;
      sreq_v <= 1'h1;
      @(posedge aclk);
      sreq_v <= 1'h0;
      repeat (2) @(posedge aclk);
   endtask : st
   task automatic at(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : at
   task automatic conclude();
      if (n_fail == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rchk(OFS_DIV, 32'h000009C2, RESP_OKAY, "divider");
      rchk(OFS_NET, 32'h000003E8, RESP_OKAY, "net timeout");
      rchk(OFS_LOC, 32'h000003E8, RESP_OKAY, "local timeout");
      rchk(OFS_MASK, 32'h00000000, RESP_OKAY, "mask");
      rchk(12'h44C, 32'h00000000, RESP_SLVERR, "unmapped");
      chk("state", 32'(sstate), 32'(ST_INIT));
   endtask : t_reset
   // Short tick and limits so expiry shows within a few dozen cycles
   task automatic t_config();
      wr(OFS_DIV, 32'h00000000, RESP_OKAY);
      rchk(OFS_DIV, 32'h000009C2, RESP_OKAY, "divider zero");
      wr(OFS_DIV, 32'h00000001, RESP_OKAY);
      rchk(OFS_DIV, 32'h00000001, RESP_OKAY, "divider one");
      wr(OFS_NET, 32'h0000FFFF, RESP_OKAY);
      rchk(OFS_NET, 32'h0000FFFF, RESP_OKAY, "net max");
      // Partial strobes: divider needs both low bytes, timeouts take single bytes
      wstrb <= 4'h1;
      wr(OFS_DIV, 32'h00000005, RESP_OKAY);
      rchk(OFS_DIV, 32'h00000001, RESP_OKAY, "divider strobe");
      wr(OFS_NET, 32'h00001202, RESP_OKAY);
      rchk(OFS_NET, 32'h0000FF02, RESP_OKAY, "net low byte");
      wstrb <= 4'hF;
      wr(OFS_NET, 32'h00000002, RESP_OKAY);
      wr(OFS_LOC, 32'h00000003, RESP_OKAY);
      wr(OFS_MASK, 32'h00000001, RESP_OKAY);
      wr(12'h44C, 32'h00000000, RESP_SLVERR);
      st(ST_OP);
      chk("state", 32'(sstate), 32'(ST_INIT));
      st(ST_PREOP);
      st(ST_SAFEOP);
      chk("state", 32'(sstate), 32'(ST_SAFEOP));
      chk("out safeop", {24'h0, odrv}, 32'h00000000);
      st(ST_OP);
      chk("out op", {24'h0, odrv}, 32'h000000A5);
   endtask : t_config
   task automatic t_net();
      repeat (8)
      begin
         at(4);
         chk("out kicked", {24'h0, odrv}, 32'h000000A5);
      end
      wr(OFS_NET, 32'h00000005, RESP_OKAY);
      rchk(OFS_NET, 32'h00000002, RESP_OKAY, "net locked");
      @(posedge aclk);
      net_on <= 1'h0;
      at(2);
      chk("out early", {24'h0, odrv}, 32'h000000A5);
      at(14);
      chk("out expired", {24'h0, odrv}, 32'h00000000);
      chk("state kept", 32'(sstate), 32'(ST_OP));
      chk("irq net", {31'h0, irq}, 32'h00000001);
      at(20);
      chk("out held", {24'h0, odrv}, 32'h00000000);
      @(posedge aclk);
      net_on <= 1'h1;
      at(6);
      chk("out back", {24'h0, odrv}, 32'h000000A5);
      rchk(OFS_STAT, 32'h00000001, RESP_OKAY, "status");
      rchk(OFS_STAT, 32'h00000000, RESP_OKAY, "status clear");
      chk("irq clear", {31'h0, irq}, 32'h00000000);
   endtask : t_net
   // Local expiry reports only; outputs keep following the request
   task automatic t_local();
      @(posedge aclk);
      loc_on <= 1'h0;
      at(25);
      rchk(OFS_LIVE, 32'h00000032, RESP_OKAY, "live");
      chk("out local", {24'h0, odrv}, 32'h000000A5);
      rchk(OFS_STAT, 32'h00000002, RESP_OKAY, "status local");
      @(posedge aclk);
      loc_on <= 1'h1;
   endtask : t_local
   task automatic t_off();
      st(ST_INIT);
      wr(OFS_NET, 32'h00000000, RESP_OKAY);
      st(ST_PREOP);
      st(ST_SAFEOP);
      st(ST_OP);
      @(posedge aclk);
      net_on <= 1'h0;
      at(40);
      chk("out disabled", {24'h0, odrv}, 32'h000000A5);
      chk("irq disabled", {31'h0, irq}, 32'h00000000);
   endtask : t_off
   // ==========================================================
   // Main sequence and hang guard
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      oreq <= 8'hA5;
      t_reset();
      t_config();
      t_net();
      t_local();
      t_off();
      conclude();
   end
   // Whole run needs well under 2000 cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      n_fail++;
      conclude();
   end
endmodule : dwd_top_tb
`default_nettype wire
